/* rtl/srd_params.svh */
`ifndef SRD_PARAMS_SVH
`define SRD_PARAMS_SVH

`define SRD_WIDTH       8
`define SRD_FIFO_DEPTH  32
`define SRD_CHAIN_RST   8'h00
`define SRD_STORE_RST   8'h00
`define SRD_DRAIN_OFF   8'h00
`define SRD_DRAIN_LEVEL 8'h00
`define SRD_FIRST_STAGE 0
`define SRD_LAST_STAGE  7

`endif

/* rtl/srd_pkg.sv */
`include "srd_params.svh"

package srd_pkg;

	typedef logic [`SRD_WIDTH-1:0] srd_word_t;

	// Shift chain, clocked by the shift clock
	typedef struct packed {
		srd_word_t chain;
	} srd_link_state_t;

	// Core state, clocked by clk
	typedef struct packed {
		logic      load_s1;
		logic      load_s2;
		logic      load_s3;
		logic      oe_n_s1;
		logic      oe_n_s2;
		srd_word_t chain_s1;
		srd_word_t chain_s2;
		srd_word_t store;
		srd_word_t drain_on;
		logic      full;
		logic      dropped;
	} srd_core_state_t;

endpackage

/* rtl/srd_fifo.sv */
`timescale 1ns/1ns

module srd_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
)
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [AW-1:0]    wp;
		logic [AW-1:0]    rp;
		logic [AW:0]      cnt;
		logic             ov;
		logic [WIDTH-1:0] od;
	} fifo_state_t;

	fifo_state_t      s_r;
	fifo_state_t      s_nxt;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (s_r.cnt != FULL_CNT);
	assign out_valid = s_r.ov;
	assign out_data  = s_r.od;
	assign push      = in_valid && in_ready;
	// Refill the output word when it is empty or being taken
	assign pop       = (s_r.cnt != '0) && (!s_r.ov || out_ready);

	always_comb
	begin
		s_nxt = s_r;
		if (push)
		begin
			s_nxt.wp = s_r.wp + AW'(1);
		end
		if (pop)
		begin
			s_nxt.rp = s_r.rp + AW'(1);
			s_nxt.od = mem[s_r.rp];
			s_nxt.ov = 1'b1;
		end
		else if (out_ready)
		begin
			s_nxt.ov = 1'b0;
		end
		s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[s_r.wp] <= in_data;
		end
	end

	chk_fifo_bound: assert property (@(posedge clk) disable iff (rst)
		s_r.cnt <= FULL_CNT)
		else $error("fifo count above depth");

endmodule

/* rtl/srd_top.sv */
// Functional notes
// [R01] Eight-stage serial shift chain feeds an eight-bit storage register.
// [R02] Each shift clock rising edge advances the chain one stage.
// [R03] Storage clock rising edge captures all eight chain stages; here via a FIFO, the word dropped and flagged when the FIFO is full.
// [R04] With clear high, storage contents pass on toward the output buffers.
// [R05] Clear low forces all chain stages to zero, without the shift clock.
// [R06] Output enable high forces every buffer bit low, all drains off.
// [R07] Output enable low lets buffers follow the storage register.
// [R08] Last chain stage drives the cascade output for chaining.
// [R09] Drain off when buffer bit low, sinking when high.
// [R10] Serial bit enters stage one; each stage takes its predecessor.
`timescale 1ns/1ns
`include "srd_params.svh"

module srd_top
	import srd_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       shift_clock,
	input  wire logic       shift_clear_n,
	input  wire logic       chain_input,
	input  wire logic       storage_load_clock,
	input  wire logic       output_enable_n,
	input  wire logic       hold_update,
	input  wire srd_word_t  drain_in,
	output srd_word_t       drain_out,
	output srd_word_t       drain_oe,
	output logic            cascade_out,
	output logic            fifo_full,
	output logic            word_dropped
);

	srd_link_state_t lk_r;
	srd_link_state_t lk_nxt;
	srd_core_state_t cr_r;
	srd_core_state_t cr_nxt;
	logic            push_vld;
	logic            fifo_in_ready;
	logic            fifo_out_valid;
	srd_word_t       fifo_out_data;
	logic            fifo_take;

	// Link domain: the shift chain itself
	always_comb
	begin
		lk_nxt = lk_r;
		lk_nxt.chain = {lk_r.chain[`SRD_LAST_STAGE-1:0], chain_input}; // [R02] [R10]
	end

	// Clear acts without the shift clock, which may be stopped
	always_ff @(posedge shift_clock or negedge shift_clear_n)
	begin
		if (!shift_clear_n)
		begin
			lk_r.chain <= `SRD_CHAIN_RST; // [R05]
		end
		else
		begin
			lk_r <= lk_nxt; // [R01]
		end
	end

	assign cascade_out = lk_r.chain[`SRD_LAST_STAGE]; // [R08]

	// Core domain. The chain is quiet while the storage clock rises, so its
	// bits cross through plain two-stage synchronisers and are taken only
	// on the synchronised storage edge.
	assign push_vld  = cr_r.load_s2 && !cr_r.load_s3; // [R03]
	assign fifo_take = fifo_out_valid && !hold_update;

	always_comb
	begin
		cr_nxt = cr_r;
		cr_nxt.load_s1  = storage_load_clock;
		cr_nxt.load_s2  = cr_r.load_s1;
		cr_nxt.load_s3  = cr_r.load_s2;
		cr_nxt.oe_n_s1  = output_enable_n;
		cr_nxt.oe_n_s2  = cr_r.oe_n_s1;
		cr_nxt.chain_s1 = lk_r.chain;
		cr_nxt.chain_s2 = cr_r.chain_s1;
		cr_nxt.full     = !fifo_in_ready;
		if (push_vld && !fifo_in_ready)
		begin
			cr_nxt.dropped = 1'b1;
		end
		if (fifo_take)
		begin
			cr_nxt.store = fifo_out_data; // [R03]
		end
		if (cr_r.oe_n_s2)
		begin
			cr_nxt.drain_on = `SRD_DRAIN_OFF; // [R06]
		end
		else
		begin
			cr_nxt.drain_on = cr_r.store; // [R04] [R07]
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cr_r         <= '0;
			cr_r.load_s1 <= 1'b0;
			cr_r.oe_n_s1 <= 1'b1;
			cr_r.oe_n_s2 <= 1'b1;
			cr_r.store   <= `SRD_STORE_RST;
		end
		else
		begin
			cr_r <= cr_nxt;
		end
	end

	srd_fifo
	#(
		.WIDTH (`SRD_WIDTH),
		.DEPTH (`SRD_FIFO_DEPTH)
	)
	u_fifo
	(
		.clk       (clk),
		.rst       (rst),
		.in_valid  (push_vld),
		.in_data   (cr_r.chain_s2),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (!hold_update)
	);

	// Open drain: enable high pulls the pin low, i.e. the drain conducts
	assign drain_out    = `SRD_DRAIN_LEVEL;
	assign drain_oe     = cr_r.drain_on; // [R09]
	assign fifo_full    = cr_r.full;
	assign word_dropped = cr_r.dropped;

	sequence s_take;
		fifo_take;
	endsequence

	sequence s_load_rise;
		cr_r.load_s2 && !cr_r.load_s3;
	endsequence

	sequence s_oe_rise;
		$rose(cr_r.oe_n_s1);
	endsequence

	sequence s_oe_fall;
		$fell(cr_r.oe_n_s1);
	endsequence

	chk_shift_entry: assert property (@(posedge shift_clock) disable iff (!shift_clear_n) // [R10]
		1'b1 |=> lk_r.chain[`SRD_FIRST_STAGE] == $past(chain_input))
		else $error("serial bit did not enter first stage");

	chk_shift_advance: assert property (@(posedge shift_clock) disable iff (!shift_clear_n) // [R02]
		1'b1 |=> lk_r.chain[`SRD_LAST_STAGE:1] == $past(lk_r.chain[`SRD_LAST_STAGE-1:0]))
		else $error("chain did not advance one stage");

	chk_cascade_tail: assert property (@(posedge shift_clock) disable iff (!shift_clear_n) // [R08]
		1'b1 |=> cascade_out == $past(lk_r.chain[`SRD_LAST_STAGE-1]))
		else $error("cascade output not last stage");

	chk_clear_zero: assert property (@(posedge clk) disable iff (rst) // [R05]
		!shift_clear_n [*2] |-> lk_r.chain == `SRD_CHAIN_RST)
		else $error("chain not cleared");

	chk_capture_push: assert property (@(posedge clk) disable iff (rst) // [R01]
		s_load_rise |-> cr_r.chain_s2 == lk_r.chain)
		else $error("captured word differs from chain");

	chk_store_load: assert property (@(posedge clk) disable iff (rst) // [R03]
		s_take |=> cr_r.store == $past(fifo_out_data))
		else $error("storage register missed a word");

	chk_pass_through: assert property (@(posedge clk) disable iff (rst) // [R04]
		s_take ##1 !cr_r.oe_n_s2 |=> drain_oe == $past(fifo_out_data, 2))
		else $error("stored word did not reach the drains");

	chk_oe_blank: assert property (@(posedge clk) disable iff (rst) // [R06]
		cr_r.oe_n_s2 |=> drain_oe == `SRD_DRAIN_OFF)
		else $error("drains on while outputs disabled");

	chk_oe_follow: assert property (@(posedge clk) disable iff (rst) // [R07]
		!cr_r.oe_n_s2 && $stable(cr_r.store) |=> drain_oe == $past(cr_r.store))
		else $error("drains do not follow storage");

	chk_drop_flag: assert property (@(posedge clk) disable iff (rst) // [R03]
		s_load_rise and !fifo_in_ready |=> word_dropped [*2])
		else $error("lost word not flagged");

	chk_accept_clean: assert property (@(posedge clk) disable iff (rst) // [R03]
		s_load_rise and fifo_in_ready |=> word_dropped == $past(word_dropped))
		else $error("accepted word flagged as lost");

	chk_drop_sticky: assert property (@(posedge clk) disable iff (rst) // [R03]
		word_dropped |=> word_dropped)
		else $error("lost word flag cleared");

	chk_store_quiet: assert property (@(posedge clk) disable iff (rst) // [R03]
		!fifo_take |=> $stable(cr_r.store))
		else $error("storage changed without a word");

	chk_oe_off_lag: assert property (@(posedge clk) disable iff (rst) // [R06]
		s_oe_rise |-> ##2 drain_oe == `SRD_DRAIN_OFF)
		else $error("drains still on after disable");

	chk_oe_on_lag: assert property (@(posedge clk) disable iff (rst) // [R07]
		s_oe_fall |-> ##2 drain_oe == $past(cr_r.store))
		else $error("drains did not return to storage");

	chk_cascade_clear: assert property (@(posedge clk) disable iff (rst) // [R05]
		!shift_clear_n [*2] |-> !cascade_out)
		else $error("cascade output high while cleared");

	chk_clear_link: assert property (@(posedge shift_clock) // [R05]
		!shift_clear_n |-> lk_r.chain == `SRD_CHAIN_RST)
		else $error("chain shifted while cleared");

endmodule

/* verif/srd_host.sv */
`timescale 1ns/1ns

module srd_host
	import srd_pkg::*;
(
	output logic shift_clock,
	output logic chain_input,
	output logic storage_load_clock
);
	initial
	begin
		shift_clock = 1'b0;
		chain_input = 1'b0;
		storage_load_clock = 1'b0;
	end

	// MSB first; link clock runs only inside the frame
	task automatic send(input srd_word_t w);
		for (int i = 7; i >= 0; i--)
		begin
			chain_input = w[i];
			#3 shift_clock = 1'b1;
			#3 shift_clock = 1'b0;
		end
		chain_input = ~w[0];
		#400 storage_load_clock = 1'b1;
		#400 storage_load_clock = 1'b0;
		#300;
	endtask
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns

module tb_top
	import srd_pkg::*;
;
	logic      clk = 1'b0;
	logic      rst = 1'b1;
	logic      shift_clear_n = 1'b1;
	logic      output_enable_n = 1'b1;
	logic      hold_update = 1'b0;
	logic      shift_clock;
	logic      chain_input;
	logic      storage_load_clock;
	logic      cascade_out;
	logic      fifo_full;
	logic      word_dropped;
	srd_word_t drain_out;
	srd_word_t drain_oe;
	int        miscompares = 0;
	int        num_checks = 0;

	always #50 clk = ~clk;

	srd_host i_srd_host (
		.shift_clock        (shift_clock),
		.chain_input        (chain_input),
		.storage_load_clock (storage_load_clock)
	);

	srd_top i_srd_top (
		.clk                (clk),
		.rst                (rst),
		.shift_clock        (shift_clock),
		.shift_clear_n      (shift_clear_n),
		.chain_input        (chain_input),
		.storage_load_clock (storage_load_clock),
		.output_enable_n    (output_enable_n),
		.hold_update        (hold_update),
		.drain_in           (8'h00),
		.drain_out          (drain_out),
		.drain_oe           (drain_oe),
		.cascade_out        (cascade_out),
		.fifo_full          (fifo_full),
		.word_dropped       (word_dropped)
	);

	task results;
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input srd_word_t got, input srd_word_t exp);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Bounded wait for the drains to show a word
	task wait_oe(input srd_word_t exp);
		int n;
		n = 0;
		while (drain_oe !== exp && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		chk(drain_oe, exp);
		if (drain_oe !== exp)
			results;
	endtask

	task sc_load;
		@(posedge clk) output_enable_n <= 1'b0;
		i_srd_host.send(8'h96);
		chk({7'h00, cascade_out}, 8'h01);
		wait_oe(8'h96);
		i_srd_host.send(8'h3c);
		wait_oe(8'h3c);
		chk(drain_out, 8'h00);
	endtask

	task sc_enable;
		@(posedge clk) output_enable_n <= 1'b1;
		wait_oe(8'h00);
		@(posedge clk) output_enable_n <= 1'b0;
		wait_oe(8'h3c);
	endtask

	task sc_clear;
		@(posedge clk) shift_clear_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk({7'h00, cascade_out}, 8'h00);
		chk(drain_oe, 8'h3c);
		i_srd_host.send(8'hff);
		chk({7'h00, cascade_out}, 8'h00);
		wait_oe(8'h00);
		@(posedge clk) shift_clear_n <= 1'b1;
	endtask

	task sc_fifo;
		@(posedge clk) hold_update <= 1'b1;
		for (int i = 0; i < 35; i++)
			i_srd_host.send(srd_word_t'(i + 1));
		chk({6'h00, fifo_full, word_dropped}, 8'h03);
		@(posedge clk) hold_update <= 1'b0;
		wait_oe(8'h21);
		chk({7'h00, fifo_full}, 8'h00);
	endtask

	initial
	begin
		// Clear falls after time zero so the chain sees its edge
		@(posedge clk) shift_clear_n <= 1'b0;
		repeat (11) @(posedge clk);
		rst <= 1'b0;
		shift_clear_n <= 1'b1;
		@(posedge clk);
		chk(drain_oe, 8'h00);
		sc_load;
		sc_enable;
		sc_clear;
		sc_fifo;
		results;
	end
endmodule
